// ### core/sicm_defines.svh
// constants for the system integrity control/status block
// assumes a single 100 MHz bus clock and an AHB-Lite register slave
//
// Behaviour
// R1 - page select bit 7 routes accesses to page 0 or page 1 layout
// R2 - supply warning irq request on every flag change while enabled
// R3 - pending supply warning irq clears when CPU vectors into its routine
// R4 - supply warning flag read-only, follows comparator: 1 below threshold
// R5 - voltage-drop reset flag set by low-voltage reset, cleared by writing zero
// R6 - voltage-drop reset flag undefined when low-voltage detector disabled
// R7 - pin or watchdog reset leaves voltage-drop reset flag untouched; resetn clears it here
// R8 - software writes zero to reserved bits of both pages
// R9 - clock fail irq enable allows irq on detection, no effect when pll off
// R10 - clock fail flag set on oscillator loss, read clears after recovery
// R11 - clock fail flag reads zero while pll disabled
// R12 - watchdog flag set by watchdog reset, cleared by zero write or low-voltage reset
// R13 - reset flag pair encodes cause: pin 00, watchdog 01, low voltage 1x
// R14 - fixed mode 0 gives pll-driven vco, 1 grounds vco for fixed frequency
// R15 - programming session entry forces fixed mode, pll enable, source select to one
// R16 - pll lock bit read-only, set by hardware when pll locked
// R17 - pll enable switches pll and detector; disable refused while pll source selected; allowed here while src_by_option is set
// R18 - selecting pll refused while pll off; ignored when option selects source
// R19 - events reach CPU only with enable set and CPU mask cleared
// R20 - pll lock reads zero while pll enable is zero
`ifndef SICM_DEFINES_SVH
`define SICM_DEFINES_SVH

// byte address of the shared register word
`define SICM_CSR_ADDR 12'h040

// bit positions, page 0
`define SICM_PAGE_BIT 7
`define SICM_P0_WARN_IE_BIT 6
`define SICM_P0_WARN_FLAG_BIT 5
`define SICM_P0_LVD_RF_BIT 4
`define SICM_P0_CF_IE_BIT 2
`define SICM_P0_CF_DET_BIT 1
`define SICM_P0_WDG_RF_BIT 0

// bit positions, page 1
`define SICM_P1_FIXED_BIT 5
`define SICM_P1_LOCK_BIT 4
`define SICM_P1_PLL_EN_BIT 3
`define SICM_P1_SRC_SEL_BIT 1

// reset values of software-owned bits
`define SICM_RST_BIT 1'b0

`endif

// ### core/sicm_pkg.sv
// types for the system integrity control/status block
// assumes sicm_defines.svh supplies the numeric constants
package sicm_pkg;
  typedef logic [31:0] sicm_word_t;
  typedef logic [7:0] sicm_byte_t;
endpackage : sicm_pkg

// ### core/sicm_top.sv
// system integrity control/status register unit with ahb-lite slave
// assumes analog status inputs arrive asynchronously and are synchronised here
`timescale 1ns/100ps
`include "sicm_defines.svh"
module sicm_top
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire sicm_pkg::sicm_word_t hwdata,
  input wire logic hready,
  output sicm_pkg::sicm_word_t hrdata,
  output logic hreadyout,
  output logic hresp,
  // reset cause strobes from the reset controller, one cycle after release; low-voltage detector option
  input wire logic lvd_reset_seen,
  input wire logic wdg_reset_seen,
  input wire logic lvd_option_en,
  // analog and clock monitors, asynchronous
  input wire logic warn_comparator,
  input wire logic osc_lost,
  input wire logic pll_locked_raw,
  // option and programming session
  input wire logic src_by_option,
  input wire logic icc_entry,
  // cpu interrupt interface
  input wire logic cpu_irq_masked,
  input wire logic warn_vector_taken,
  output logic warn_irq,
  output logic clock_fail_irq,
  // clock control outputs
  output logic osc_fixed_mode,
  output logic backup_pll_en,
  output logic clock_source_sel
);
  import sicm_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // input synchronisers
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
    end
    else
    begin
      sync1_q <= {pll_locked_raw, osc_lost, warn_comparator};
      sync2_q <= sync1_q;
    end
  end

  logic warn_s;
  logic osc_lost_s;
  logic lock_s;
  assign warn_s = sync2_q[0];
  assign osc_lost_s = sync2_q[1];
  assign lock_s = sync2_q[2];

  //////////////////////////////////////////////////////////////////////////////
  // bus address phase capture
  logic wr_pend_q;
  logic rd_pend_q;
  logic addr_hit;
  logic xfer;

  assign xfer = hsel && hready && htrans[1];
  assign addr_hit = (haddr[11:2] == 10'(`SICM_CSR_ADDR >> 2));

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
    end
    else
    begin
      wr_pend_q <= xfer && hwrite && (haddr[11:2] == 10'(`SICM_CSR_ADDR >> 2));
      rd_pend_q <= xfer && !hwrite && (haddr[11:2] == 10'(`SICM_CSR_ADDR >> 2));
    end
  end

  // zero wait states, always okay
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  //////////////////////////////////////////////////////////////////////////////
  // software-owned control bits
  logic page_q;
  logic warn_ie_q;
  logic cf_ie_q;
  logic fixed_q;
  logic pll_en_q;
  logic src_sel_q;
  sicm_byte_t wb;
  assign wb = hwdata[7:0];

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      page_q <= `SICM_RST_BIT;
      warn_ie_q <= `SICM_RST_BIT;
      cf_ie_q <= `SICM_RST_BIT;
      fixed_q <= `SICM_RST_BIT;
      pll_en_q <= `SICM_RST_BIT;
      src_sel_q <= `SICM_RST_BIT;
    end
    else if (icc_entry)
    begin
      fixed_q <= 1'b1; // R15
      pll_en_q <= 1'b1; // R15
      src_sel_q <= 1'b1; // R15
    end
    else if (wr_pend_q)
    begin
      page_q <= wb[`SICM_PAGE_BIT]; // R1
      if (!page_q)
      begin
        warn_ie_q <= wb[`SICM_P0_WARN_IE_BIT];
        cf_ie_q <= wb[`SICM_P0_CF_IE_BIT];
      end
      else
      begin
        fixed_q <= wb[`SICM_P1_FIXED_BIT]; // R14
        // disable refused while pll source selected by software, even if this write clears the selection
        if (wb[`SICM_P1_PLL_EN_BIT] || !(src_sel_q && !src_by_option))
          pll_en_q <= wb[`SICM_P1_PLL_EN_BIT]; // R17
        // selecting pll refused while pll is off
        if (!wb[`SICM_P1_SRC_SEL_BIT] || pll_en_q)
          src_sel_q <= wb[`SICM_P1_SRC_SEL_BIT]; // R18
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // reset cause flags; cleared by resetn, then set by the cause strobes after release
  logic lvd_rf_q;
  logic wdg_rf_q;
  logic wr_p0;
  assign wr_p0 = wr_pend_q && !page_q;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      lvd_rf_q <= 1'b0;
    else if (lvd_reset_seen)
      lvd_rf_q <= 1'b1; // R5 R7
    else if (wr_p0 && !wb[`SICM_P0_LVD_RF_BIT])
      lvd_rf_q <= 1'b0; // R5
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      wdg_rf_q <= 1'b0;
    else if (lvd_reset_seen)
      wdg_rf_q <= 1'b0; // R12 R13
    else if (wdg_reset_seen)
      wdg_rf_q <= 1'b1; // R12 R13
    else if (wr_p0 && !wb[`SICM_P0_WDG_RF_BIT])
      wdg_rf_q <= 1'b0; // R12
  end

  // undefined when detector off; reported as zero
  logic lvd_rf_view;
  assign lvd_rf_view = lvd_option_en && lvd_rf_q; // R6

  //////////////////////////////////////////////////////////////////////////////
  // clock fail detection
  logic cf_det_q;
  logic rd_p0;
  assign rd_p0 = rd_pend_q && !page_q;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      cf_det_q <= 1'b0;
    else if (!pll_en_q)
      cf_det_q <= 1'b0; // R11
    else if (osc_lost_s)
      cf_det_q <= 1'b1; // R10
    else if (rd_p0)
      cf_det_q <= 1'b0; // R10
  end

  //////////////////////////////////////////////////////////////////////////////
  // supply warning edge interrupt
  logic warn_q;
  logic warn_pend_q;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      warn_q <= 1'b0;
      warn_pend_q <= 1'b0;
    end
    else
    begin
      warn_q <= warn_s; // R4
      if (warn_ie_q && (warn_s != warn_q))
        warn_pend_q <= 1'b1; // R2
      else if (warn_vector_taken || !warn_ie_q)
        warn_pend_q <= 1'b0; // R3
    end
  end

  assign warn_irq = warn_pend_q && !cpu_irq_masked; // R19
  assign clock_fail_irq = cf_ie_q && pll_en_q && cf_det_q && !cpu_irq_masked; // R9 R19

  //////////////////////////////////////////////////////////////////////////////
  // read data
  logic lock_view;
  assign lock_view = lock_s && pll_en_q; // R16 R20

  sicm_byte_t rd_byte;
  always_comb
  begin
    rd_byte = 8'h00;
    rd_byte[`SICM_PAGE_BIT] = page_q;
    if (!page_q)
    begin
      rd_byte[`SICM_P0_WARN_IE_BIT] = warn_ie_q;
      rd_byte[`SICM_P0_WARN_FLAG_BIT] = warn_q; // R4
      rd_byte[`SICM_P0_LVD_RF_BIT] = lvd_rf_view;
      rd_byte[`SICM_P0_CF_IE_BIT] = cf_ie_q;
      rd_byte[`SICM_P0_CF_DET_BIT] = cf_det_q && pll_en_q; // R11
      rd_byte[`SICM_P0_WDG_RF_BIT] = wdg_rf_q;
    end
    else
    begin
      rd_byte[`SICM_P1_FIXED_BIT] = fixed_q;
      rd_byte[`SICM_P1_LOCK_BIT] = lock_view;
      rd_byte[`SICM_P1_PLL_EN_BIT] = pll_en_q;
      rd_byte[`SICM_P1_SRC_SEL_BIT] = src_sel_q;
    end
  end

  assign hrdata = rd_pend_q ? {24'h000000, rd_byte} : 32'h00000000;

  assign osc_fixed_mode = fixed_q; // R14
  assign backup_pll_en = pll_en_q;
  assign clock_source_sel = src_sel_q || src_by_option; // R18

  logic unused;
  assign unused = addr_hit ^ (|hsize) ^ htrans[0];
endmodule : sicm_top

// ### bench/sicm_sva.sv
// port checker for the integrity register block
// assumes one clock and an async active-low reset
`timescale 1ns/100ps
module sicm_sva
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // bus answer
  input wire sicm_pkg::sicm_word_t hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // control inputs
  input wire logic src_by_option,
  input wire logic icc_entry,
  input wire logic cpu_irq_masked,
  input wire logic warn_vector_taken,
  // outputs
  input wire logic warn_irq,
  input wire logic clock_fail_irq,
  input wire logic osc_fixed_mode,
  input wire logic backup_pll_en,
  input wire logic clock_source_sel
);
  import sicm_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  chk_bus_okay: assert property (hreadyout && !hresp && hrdata[31:8] == 24'h0)
    else $error("bus answer wrong");
  chk_cf_irq_gate: assert property (clock_fail_irq |-> backup_pll_en && !cpu_irq_masked)
    else $error("clock fail irq ungated");
  chk_warn_mask: assert property (warn_irq |-> !cpu_irq_masked)
    else $error("warn irq while masked");
  chk_pll_off_refused: assert property ($fell(backup_pll_en) |-> !$past(clock_source_sel) || $past(src_by_option))
    else $error("pll disabled while selected");
  chk_pll_holds: assert property (backup_pll_en && clock_source_sel && !src_by_option |=> backup_pll_en)
    else $error("pll dropped");
  chk_sel_refused: assert property ($rose(clock_source_sel) && !src_by_option |-> $past(backup_pll_en) || $past(icc_entry))
    else $error("pll selected while off");
  chk_src_option: assert property (src_by_option |-> clock_source_sel)
    else $error("option source ignored");
  chk_icc_forces: assert property (icc_entry |=> osc_fixed_mode && backup_pll_en && clock_source_sel)
    else $error("session entry not forced");
  chk_vector_clears: assert property (warn_vector_taken |=> !warn_irq)
    else $error("warn irq not cleared");
  cover property ($rose(warn_irq));
  cover property ($rose(clock_fail_irq));
  cover property ($rose(clock_source_sel) && !src_by_option);
endmodule : sicm_sva
bind sicm_top sicm_sva sicm_sva_inst (.*);

// ### bench/sicm_top_tb.sv
// self-checking bench for the integrity register block
// assumes the checker is bound in and a zero-wait slave
`timescale 1ns/100ps
`include "sicm_defines.svh"
module sicm_top_tb;
  import sicm_pkg::*;
  logic clk, resetn, hsel, hwrite, hready, hreadyout, hresp, lvd_reset_seen, wdg_reset_seen;
  logic lvd_option_en, warn_comparator, osc_lost, pll_locked_raw, src_by_option, icc_entry;
  logic cpu_irq_masked, warn_vector_taken, warn_irq, clock_fail_irq, osc_fixed_mode, backup_pll_en;
  logic clock_source_sel;
  logic [11:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  sicm_word_t hwdata, hrdata, rd_s;
  int miscompares = 0;
  int tests_run = 0;
  int cyc = 0;
  assign hready = hreadyout;
  sicm_top sicm_top_inst (.*);
  initial
  begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  // pre-edge copy avoids racing the data phase closing
  always @(posedge clk) rd_s <= hrdata;
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      miscompares++;
      results();
    end
  end
  //////////////////////////////////////////////////////////////
  task results();
    $display("tests_run %0d miscompares %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : results
  task chk(input string n, input sicm_word_t s, input sicm_word_t e);
    tests_run++;
    if (s !== e)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task w(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : w
  task bus(input logic wr, input sicm_byte_t d, output sicm_word_t r);
    hsel <= 1;
    haddr <= `SICM_CSR_ADDR;
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    hsel <= 0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    #1;
    r = rd_s;
  endtask : bus
  task wr(input sicm_byte_t d);
    sicm_word_t r;
    bus(1'b1, d, r);
  endtask : wr
  task rdc(input string n, input sicm_byte_t e);
    sicm_word_t r;
    bus(1'b0, 8'h00, r);
    chk(n, r, {24'h0, e});
  endtask : rdc
  task pulse_w(input logic l);
    if (l) lvd_reset_seen <= 1;
    else wdg_reset_seen <= 1;
    w(1);
    {lvd_reset_seen, wdg_reset_seen} <= 2'h0;
    w(1);
  endtask : pulse_w
  //////////////////////////////////////////////////////////////
  initial
  begin
    {hsel, hwrite, haddr, htrans, hwdata, lvd_reset_seen, wdg_reset_seen, warn_comparator} = '0;
    {osc_lost, src_by_option, icc_entry, cpu_irq_masked, warn_vector_taken, resetn} = '0;
    {hsize, lvd_option_en, pll_locked_raw} = 5'h0B;
    w(12);
    resetn <= 1;
    w(1);
    rdc("p0", 8'h00);
    wr(8'h80);
    rdc("p1", 8'h80);
    $display("test reset done");
    wr(8'h82);
    rdc("sel_off", 8'h80);
    wr(8'h88);
    w(4);
    rdc("lock", 8'h98);
    wr(8'h8A);
    rdc("sel_on", 8'h9A);
    wr(8'h82);
    rdc("dis_ref", 8'h9A);
    wr(8'hA8);
    rdc("fixed", 8'hB8);
    chk("fixed_pin", osc_fixed_mode, 32'h1);
    $display("test pll done");
    wr(8'h28);
    wr(8'h04);
    osc_lost <= 1;
    w(4);
    rdc("css_set", 8'h06);
    chk("css_irq", clock_fail_irq, 32'h1);
    cpu_irq_masked <= 1;
    w(1);
    chk("css_mask", clock_fail_irq, 32'h0);
    {cpu_irq_masked, osc_lost} <= 2'h0;
    w(4);
    rdc("css_rec", 8'h06);
    rdc("css_clr", 8'h04);
    osc_lost <= 1;
    w(4);
    wr(8'h80);
    wr(8'h00);
    rdc("css_off", 8'h00);
    osc_lost <= 0;
    $display("test clock guard done");
    wr(8'h40);
    warn_comparator <= 1;
    w(6);
    rdc("warn", 8'h60);
    chk("warn_fall", warn_irq, 32'h1);
    warn_vector_taken <= 1;
    w(1);
    warn_vector_taken <= 0;
    w(1);
    chk("warn_ack", warn_irq, 32'h0);
    warn_comparator <= 0;
    w(6);
    chk("warn_rise", warn_irq, 32'h1);
    $display("test warning done");
    pulse_w(0);
    rdc("wdg", 8'h41);
    pulse_w(1);
    rdc("lvd", 8'h50);
    pulse_w(0);
    rdc("lvd_keep", 8'h51);
    lvd_option_en <= 0;
    rdc("lvd_off", 8'h41);
    lvd_option_en <= 1;
    wr(8'h00);
    rdc("clear", 8'h00);
    $display("test reset flags done");
    icc_entry <= 1;
    w(1);
    icc_entry <= 0;
    w(1);
    chk("icc", {osc_fixed_mode, backup_pll_en, clock_source_sel}, 32'h7);
    $display("test session done");
    results();
  end
endmodule : sicm_top_tb
